// [bsc_map.svh]
// Offsets, reset values and timing counts for the start-up sequencer.
// Assumes a 25 MHz clock and a 12-bit AXI4-Lite byte address.
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
`define BSC_CLK_PERIOD_NS 40
`define BSC_TICK_NS 1000000
`define BSC_TICK_CYCLES (`BSC_TICK_NS / `BSC_CLK_PERIOD_NS)
`define BSC_AUTO_SPEED 32'h0400_0000
`define BSC_ADDR_W 12
`define BSC_OFF_CTRL 12'h000
`define BSC_OFF_PARK 12'h004
`define BSC_OFF_DUTY 12'h008
`define BSC_OFF_ACCEL 12'h00C
`define BSC_OFF_HAND 12'h010
`define BSC_OFF_SENSE 12'h014
`define BSC_OFF_STATUS 12'h018
`define BSC_OFF_SPEED 12'h01C
`define BSC_CTRL_W 11
`define BSC_RST_CTRL 32'h0000_0000
`define BSC_RST_PARK 32'h0064_0180
`define BSC_RST_DUTY 32'h00C0_C040
`define BSC_RST_ACCEL 32'h0010_0100
`define BSC_RST_HAND 32'h00C8_0000
`define BSC_RST_SENSE 32'h0100_0080
`define BSC_RESP_OKAY 2'b00
`define BSC_RESP_SLVERR 2'b10
`define BSC_PARK_PATTERN 3'h5
`define BSC_SENSE_LAST 3'h5
`define BSC_STEPS 3'h6
`define BSC_TIMEOUT 16'hFFFF
`endif

// [bsc_motor.sv]
// Behavioural motor windings seen through the bridge.
// Assumes active-high gate commands; current builds only on a driven pair.
module bsc_motor #(
	parameter int ZC_HALF = 40
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Bridge and rotation
	input wire bsc_pkg::bsc_gate_t gate,
	input wire logic spin,
	// Sensed values
	output logic [7:0] phase_current,
	output logic bemf_zc
);
	import bsc_pkg::*;
	int zc_cnt;
	////////////////////////////////////////
	// Pairs with A high see least inductance; two tie on purpose
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_current <= 8'h00;
		end else if (gate.hs != 3'h0 && gate.ls != 3'h0) begin
			phase_current <= (phase_current > 8'hE0) ? 8'hF0 : phase_current + ((gate.hs == 3'h1) ? 8'h08 : 8'h02);
		end else begin
			phase_current <= 8'h00;
		end
	end
	////////////////////////////////////////
	// Comparator holds its level while the rotor stands still
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			zc_cnt <= 0;
			bemf_zc <= 1'b0;
		end else if (spin && zc_cnt == ZC_HALF - 1) begin
			zc_cnt <= 0;
			bemf_zc <= ~bemf_zc;
		end else if (spin) begin
			zc_cnt <= zc_cnt + 1;
		end
	end
endmodule : bsc_motor

// [bsc_pkg.sv]
// Types shared by the start-up and commutation sequencer.
// Assumes bsc_map.svh supplies all numeric constants.
package bsc_pkg;
	typedef struct packed {
		logic [2:0] hs;
		logic [2:0] ls;
	} bsc_gate_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PARK,
		ST_SENSE_PULSE,
		ST_SENSE_GAP,
		ST_SLOW,
		ST_OPEN,
		ST_CLOSED
	} bsc_state_t;
	typedef struct packed {
		logic [1:0] switching_side_sel;
		logic [1:0] commutation_style_sel;
		logic reverse;
		logic auto_handoff;
		logic sense_pulse_release_sel;
		logic open_loop_limit_source;
		logic [1:0] start_method_sel;
		logic run;
	} bsc_ctrl_t;
endpackage : bsc_pkg

// [bsc_properties.sv]
// Port-level checks for the start-up and commutation sequencer.
// Assumes it is bound to bsc_startup_commutation, one clock domain.
`include "bsc_map.svh"
module bsc_properties #(
	parameter int TICK_CYCLES = 8
) (
	// Clock and control
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Write channels
	input wire logic [`BSC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [`BSC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Motor side
	input wire logic [7:0] phase_current,
	input wire logic bemf_zc,
	input wire logic [7:0] duty_cmd,
	input wire bsc_pkg::bsc_gate_t gate
);
	import bsc_pkg::*;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	r_err_a: assert property (s_axi_rvalid && s_axi_rresp == `BSC_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
		else $error("error read carries data");
	stop_run_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `BSC_OFF_CTRL
		&& s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] && !s_axi_wdata[0] |-> ##[1:4] gate == 6'h00)
		else $error("bridge still driven after stop");
	no_short_a: assert property ((gate.hs & gate.ls) == 3'h0)
		else $error("shoot-through on a leg");
	one_each_a: assert property ($onehot0(gate.hs) && $onehot0(gate.ls))
		else $error("more than one switch per side");
	ls_full_a: assert property (|gate.hs |-> |gate.ls)
		else $error("high side on without low side");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rresp == `BSC_RESP_SLVERR);
	cover property (gate.hs != 3'h0 && gate.ls != 3'h0);
endmodule : bsc_properties

// [bsc_startup_commutation.sv]
// Start-up and six-step commutation sequencer with an AXI4-Lite register file.
// Assumes current samples and zero-cross level come from outside the clock domain.
//
// Contract
// - Method 00b parks with phase C high and phase B low for park time.
// - Park duty ramps from zero at the ramp rate up to park duty.
// - Park current cap is general or open-loop cap per limit source.
// - Method 01b parks twice; second pattern is one step on in direction.
// - Both parks reuse the single-park time, cap and ramp settings.
// - Method 10b finds position by inductive sensing, not parking.
// - Sense patterns run in order BC, CB, AB, BA, CA, AC.
// - Each pulse stops at the current threshold; elapsed time is recorded.
// - Shortest recorded rise time gives the rotor position.
// - Release 0b keeps the low-side switch on after the threshold.
// - Release 1b turns both switches of the pattern off.
// - Open loop starts at detected position plus the advance angle.
// - Method 11b runs the first cycle at slow rate, then accelerates.
// - Every position method ends by entering open-loop acceleration.
// - Open loop uses fixed duty and cycle-by-cycle cap from limit source.
// - Open-loop speed equals linear coeff times t plus half quadratic coeff t squared.
// - Auto handoff picks its own speed; otherwise the threshold register.
// - Closed loop times each step from the floating-phase zero crossing.
// - Style 00b gives six states, 120 degrees driven, 60 floating.
// - Modulation 00b chops the high side, low side held fully on.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "bsc_map.svh"
module bsc_startup_commutation #(
	parameter int TICK_CYCLES = `BSC_TICK_CYCLES,
	parameter logic [31:0] AUTO_SPEED = `BSC_AUTO_SPEED
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic [`BSC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [`BSC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog front end
	input wire logic [7:0] phase_current,
	input wire logic bemf_zc,
	// Closed-loop duty from speed control
	input wire logic [7:0] duty_cmd,
	// Bridge gates
	output bsc_pkg::bsc_gate_t gate
);
	import bsc_pkg::*;

	if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_chk
		$error("TICK_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic bsc_gate_t pattern(input logic [2:0] s);
		unique case (s)
			3'h0: pattern = '{hs: 3'b001, ls: 3'b010};
			3'h1: pattern = '{hs: 3'b001, ls: 3'b100};
			3'h2: pattern = '{hs: 3'b010, ls: 3'b100};
			3'h3: pattern = '{hs: 3'b010, ls: 3'b001};
			3'h4: pattern = '{hs: 3'b100, ls: 3'b001};
			3'h5: pattern = '{hs: 3'b100, ls: 3'b010};
			default: pattern = '{hs: 3'b000, ls: 3'b000};
		endcase
	endfunction : pattern

	function automatic logic [2:0] advance(input logic [2:0] s, input logic rev, input logic [2:0] n);
		logic [3:0] t;
		t = rev ? ({1'b0, s} + 4'h6 - {1'b0, n}) : ({1'b0, s} + {1'b0, n});
		if (t >= 4'h6) begin
			t = t - 4'h6;
		end
		advance = t[2:0];
	endfunction : advance

	// BC, CB, AB, BA, CA, AC as commutation states
	function automatic logic [2:0] sense_state(input logic [2:0] i);
		unique case (i)
			3'h0: sense_state = 3'h2;
			3'h1: sense_state = 3'h5;
			3'h2: sense_state = 3'h0;
			3'h3: sense_state = 3'h3;
			3'h4: sense_state = 3'h4;
			default: sense_state = 3'h1;
		endcase
	endfunction : sense_state

	function automatic logic [7:0] cap_sel(input logic src, input logic [7:0] gen, input logic [7:0] ol);
		cap_sel = src ? ol : gen;
	endfunction : cap_sel

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				merge[8*b +: 8] = d[8*b +: 8];
			end
		end
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////
	// Registers and fields
	logic [31:0] ctrl_reg, park_reg, duty_reg, accel_reg, hand_reg, sense_reg;
	bsc_ctrl_t ctrl;
	logic [7:0] park_duty, ramp_step, open_loop_duty_value, gen_cap, ol_cap, sense_thr;
	logic [15:0] park_time, a1, a2, slow_period, gap_len;
	logic [31:0] speed_thr;
	logic [2:0] sense_adv;

	assign ctrl = bsc_ctrl_t'(ctrl_reg[`BSC_CTRL_W-1:0]);
	assign park_duty = park_reg[7:0];
	assign ramp_step = park_reg[15:8];
	assign park_time = park_reg[31:16];
	assign open_loop_duty_value = duty_reg[7:0];
	assign gen_cap = duty_reg[15:8];
	assign ol_cap = duty_reg[23:16];
	assign a1 = accel_reg[15:0];
	assign a2 = accel_reg[31:16];
	assign speed_thr = {hand_reg[15:0], 16'h0000};
	assign slow_period = hand_reg[31:16];
	assign sense_thr = sense_reg[7:0];
	assign sense_adv = {1'b0, sense_reg[9:8]};
	assign gap_len = sense_reg[31:16];

	// Sequencer state
	bsc_state_t state_reg;
	logic [2:0] sector_reg, sense_idx, best_idx, step_cnt;
	logic [15:0] tick_cnt, time_cnt, sense_cnt, best_time;
	logic [15:0] zc_cnt, half_reg, wait_cnt;
	logic [7:0] ramp_duty, pwm_cnt, cur_s;
	logic [31:0] speed2, a2_term, phase_acc;
	logic [32:0] phase_sum;
	logic second, armed, tick, limit_hit, zc_edge;
	logic [7:0] cur_m;
	logic zc_m, zc_s, zc_d;

	assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));
	assign phase_sum = {1'b0, phase_acc} + {2'b00, speed2[31:1]};
	assign zc_edge = zc_s ^ zc_d;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: response one cycle after both halves held
	logic aw_held, w_held;
	logic [`BSC_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BSC_RESP_OKAY;
			ctrl_reg <= `BSC_RST_CTRL;
			park_reg <= `BSC_RST_PARK;
			duty_reg <= `BSC_RST_DUTY;
			accel_reg <= `BSC_RST_ACCEL;
			hand_reg <= `BSC_RST_HAND;
			sense_reg <= `BSC_RST_SENSE;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `BSC_RESP_OKAY;
				unique case ({aw_addr[`BSC_ADDR_W-1:2], 2'b00})
					`BSC_OFF_CTRL: ctrl_reg <= merge(ctrl_reg, w_data, w_strb) & 32'h0000_07FF;
					`BSC_OFF_PARK: park_reg <= merge(park_reg, w_data, w_strb);
					`BSC_OFF_DUTY: duty_reg <= merge(duty_reg, w_data, w_strb) & 32'h00FF_FFFF;
					`BSC_OFF_ACCEL: accel_reg <= merge(accel_reg, w_data, w_strb);
					`BSC_OFF_HAND: hand_reg <= merge(hand_reg, w_data, w_strb);
					`BSC_OFF_SENSE: sense_reg <= merge(sense_reg, w_data, w_strb) & 32'hFFFF_03FF;
					`BSC_OFF_STATUS, `BSC_OFF_SPEED: s_axi_bresp <= `BSC_RESP_SLVERR;
					default: s_axi_bresp <= `BSC_RESP_SLVERR;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `BSC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `BSC_RESP_OKAY;
				unique case ({s_axi_araddr[`BSC_ADDR_W-1:2], 2'b00})
					`BSC_OFF_CTRL: s_axi_rdata <= ctrl_reg;
					`BSC_OFF_PARK: s_axi_rdata <= park_reg;
					`BSC_OFF_DUTY: s_axi_rdata <= duty_reg;
					`BSC_OFF_ACCEL: s_axi_rdata <= accel_reg;
					`BSC_OFF_HAND: s_axi_rdata <= hand_reg;
					`BSC_OFF_SENSE: s_axi_rdata <= sense_reg;
					`BSC_OFF_STATUS: s_axi_rdata <= {best_time, 6'h00, best_idx, sector_reg, 1'b0, state_reg};
					`BSC_OFF_SPEED: s_axi_rdata <= {1'b0, speed2[31:1]};
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= `BSC_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; zero-cross edge only from second stage onward
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cur_m <= '0;
			cur_s <= '0;
			zc_m <= 1'b0;
			zc_s <= 1'b0;
			zc_d <= 1'b0;
		end else if (ce) begin
			cur_m <= phase_current;
			cur_s <= cur_m;
			zc_m <= bemf_zc;
			zc_s <= zc_m;
			zc_d <= zc_s;
		end
	end

	// Time base and switching period
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_cnt <= '0;
			pwm_cnt <= '0;
		end else if (ce) begin
			tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
			pwm_cnt <= pwm_cnt + 8'h01;
		end
	end

	// Cycle-by-cycle cap: a hit blanks the high side until the next period
	logic [7:0] cap_now;
	always_comb begin
		cap_now = gen_cap;
		if (state_reg == ST_PARK || state_reg == ST_SLOW || state_reg == ST_OPEN) begin
			cap_now = cap_sel(ctrl.open_loop_limit_source, gen_cap, ol_cap);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			limit_hit <= 1'b0;
		end else if (ce) begin
			if (cur_s >= cap_now) begin
				limit_hit <= 1'b1;
			end else if (pwm_cnt == 8'hFF) begin
				limit_hit <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Start-up and commutation sequencer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			sector_reg <= '0;
			second <= 1'b0;
			time_cnt <= '0;
			ramp_duty <= '0;
			step_cnt <= '0;
			sense_idx <= '0;
			sense_cnt <= '0;
			best_idx <= '0;
			best_time <= `BSC_TIMEOUT;
			speed2 <= '0;
			a2_term <= '0;
			phase_acc <= '0;
			zc_cnt <= '0;
			half_reg <= '0;
			wait_cnt <= '0;
			armed <= 1'b0;
		end else if (ce) begin
			if (!ctrl.run) begin
				state_reg <= ST_IDLE;
			end else begin
				unique case (state_reg)
					ST_IDLE: begin
						time_cnt <= '0;
						ramp_duty <= '0;
						second <= 1'b0;
						step_cnt <= '0;
						sense_idx <= '0;
						sense_cnt <= '0;
						best_idx <= '0;
						best_time <= `BSC_TIMEOUT;
						speed2 <= '0;
						a2_term <= '0;
						phase_acc <= '0;
						sector_reg <= sense_state(3'h0);
						unique case (ctrl.start_method_sel)
							2'b00, 2'b01: begin
								sector_reg <= `BSC_PARK_PATTERN;
								state_reg <= ST_PARK;
							end
							2'b10: state_reg <= ST_SENSE_PULSE;
							2'b11: state_reg <= ST_SLOW;
						endcase
					end
					ST_PARK: begin
						if (tick) begin
							time_cnt <= time_cnt + 16'h0001;
							// Saturating ramp towards the park duty
							if ({1'b0, ramp_duty} + {1'b0, ramp_step} >= {1'b0, park_duty}) begin
								ramp_duty <= park_duty;
							end else begin
								ramp_duty <= ramp_duty + ramp_step;
							end
							if (time_cnt + 16'h0001 >= park_time) begin
								time_cnt <= '0;
								ramp_duty <= '0;
								sector_reg <= advance(sector_reg, ctrl.reverse, 3'h1);
								if (ctrl.start_method_sel == 2'b01 && !second) begin
									second <= 1'b1;
								end else begin
									state_reg <= ST_OPEN;
								end
							end
						end
					end
					ST_SENSE_PULSE: begin
						sense_cnt <= sense_cnt + 16'h0001;
						if (cur_s >= sense_thr || sense_cnt == `BSC_TIMEOUT) begin
							// Strict compare keeps the earlier pattern on a tie
							if (sense_cnt < best_time) begin
								best_time <= sense_cnt;
								best_idx <= sense_state(sense_idx);
							end
							sense_cnt <= '0;
							state_reg <= ST_SENSE_GAP;
						end
					end
					ST_SENSE_GAP: begin
						sense_cnt <= sense_cnt + 16'h0001;
						if (sense_cnt >= gap_len) begin
							sense_cnt <= '0;
							if (sense_idx == `BSC_SENSE_LAST) begin
								sector_reg <= advance(best_idx, ctrl.reverse, sense_adv);
								state_reg <= ST_OPEN;
							end else begin
								sense_idx <= sense_idx + 3'h1;
								sector_reg <= sense_state(sense_idx + 3'h1);
								state_reg <= ST_SENSE_PULSE;
							end
						end
					end
					ST_SLOW: begin
						if (tick) begin
							time_cnt <= time_cnt + 16'h0001;
							if (time_cnt + 16'h0001 >= slow_period) begin
								time_cnt <= '0;
								sector_reg <= advance(sector_reg, ctrl.reverse, 3'h1);
								step_cnt <= step_cnt + 3'h1;
								if (step_cnt == `BSC_STEPS - 3'h1) begin
									state_reg <= ST_OPEN;
								end
							end
						end
					end
					ST_OPEN: begin
						// Twice the speed, stepped once per tick by the exact difference
						if (tick) begin
							speed2 <= speed2 + {15'h0000, a1, 1'b0} + a2_term + {16'h0000, a2};
							a2_term <= a2_term + {15'h0000, a2, 1'b0};
						end
						phase_acc <= phase_sum[31:0];
						if (phase_sum[32]) begin
							sector_reg <= advance(sector_reg, ctrl.reverse, 3'h1);
						end
						if (speed2[31:1] >= (ctrl.auto_handoff ? AUTO_SPEED[31:1] : speed_thr[31:1])) begin
							zc_cnt <= '0;
							armed <= 1'b0;
							state_reg <= ST_CLOSED;
						end
					end
					ST_CLOSED: begin
						zc_cnt <= (zc_cnt == 16'hFFFF) ? zc_cnt : zc_cnt + 16'h0001;
						if (zc_edge) begin
							// Step lands 30 degrees after the crossing
							half_reg <= {1'b0, zc_cnt[15:1]};
							zc_cnt <= '0;
							wait_cnt <= '0;
							armed <= 1'b1;
						end else if (armed) begin
							wait_cnt <= wait_cnt + 16'h0001;
							if (wait_cnt >= half_reg) begin
								sector_reg <= advance(sector_reg, ctrl.reverse, 3'h1);
								armed <= 1'b0;
							end
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Gate drive; only 120-degree style with high-side chopping exists
	logic [7:0] duty_now;
	logic chop;
	bsc_gate_t pat;
	always_comb begin
		pat = pattern(sector_reg);
		unique case (state_reg)
			ST_PARK: duty_now = ramp_duty;
			ST_SLOW, ST_OPEN: duty_now = open_loop_duty_value;
			default: duty_now = duty_cmd;
		endcase
		chop = (pwm_cnt < duty_now) && !limit_hit;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			gate <= '{hs: 3'b000, ls: 3'b000};
		end else if (ce) begin
			unique case (state_reg)
				ST_IDLE: gate <= '{hs: 3'b000, ls: 3'b000};
				ST_SENSE_PULSE: gate <= pat;
				ST_SENSE_GAP: begin
					if (ctrl.sense_pulse_release_sel) begin
						gate <= '{hs: 3'b000, ls: 3'b000};
					end else begin
						gate <= '{hs: 3'b000, ls: pat.ls};
					end
				end
				default: gate <= '{hs: pat.hs & {3{chop}}, ls: pat.ls};
			endcase
		end
	end

endmodule : bsc_startup_commutation

// [bsc_startup_commutation_bench.sv]
// Register-driven bench for the start-up and commutation sequencer.
// Assumes bsc_motor as the far side and a short tick.
`include "bsc_map.svh"
module bsc_startup_commutation_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import bsc_pkg::*;
	localparam int TICK = 8;
	logic clock, rst, ce, spin, rec;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bemf_zc;
	logic [31:0] s_axi_wdata, s_axi_rdata, s1, s2;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [7:0] phase_current, duty_cmd;
	bsc_gate_t gate, last, ge;
	bsc_gate_t seen_q[$];
	int fails, checks_done, n1, n2;
	logic [11:0] offs[6] = '{`BSC_OFF_CTRL, `BSC_OFF_PARK, `BSC_OFF_DUTY, `BSC_OFF_ACCEL, `BSC_OFF_HAND,
		`BSC_OFF_SENSE};
	logic [31:0] rsts[6] = '{`BSC_RST_CTRL, `BSC_RST_PARK, `BSC_RST_DUTY, `BSC_RST_ACCEL, `BSC_RST_HAND,
		`BSC_RST_SENSE};
	bsc_gate_t pats[6] = '{6'h14, 6'h22, 6'h0A, 6'h11, 6'h21, 6'h0C};
	bsc_startup_commutation #(.TICK_CYCLES(TICK), .AUTO_SPEED(32'h0000_0000)) u_dut (.clock, .rst, .ce,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phase_current,
		.bemf_zc, .duty_cmd, .gate);
	bsc_motor u_motor (.clock, .rst, .gate, .spin, .phase_current, .bemf_zc);
	////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Gate change log, only while armed
	always @(posedge clock) begin
		if (rec && gate !== last) begin
			seen_q.push_back(gate);
			last = gate;
		end
	end
	////////////////////////////////////////
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad = 1'b0, wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clock);
			if (!ad && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clock); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge clock);
	endtask : wr
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask : rd_reg
	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		rd_reg(a, d, rr);
		check(n, d & m, e);
	endtask : rc
	task automatic count_hs(output int c);
		c = 0;
		repeat (256) begin
			@(posedge clock);
			if (gate.hs != 3'h0) c++;
		end
	endtask : count_hs
	task automatic wait_hs(input logic [2:0] h);
		int i = 0;
		while (gate.hs !== h && i < 2000) begin
			@(posedge clock);
			i++;
		end
	endtask : wait_hs
	task automatic stop_run();
		wr(`BSC_OFF_CTRL, 32'h0000_0000, `BSC_RESP_OKAY);
		repeat (4) @(posedge clock);
	endtask : stop_run
	////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge clock);
		fails++;
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		spin = 1'b0;
		rec = 1'b0;
		last = '0;
		duty_cmd = 8'h80;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		foreach (offs[i]) rc("reset", offs[i], 32'hFFFF_FFFF, rsts[i]);
		rd_reg(12'h020, s1, rr);
		check("unmapped", {rr, s1[29:0]}, {`BSC_RESP_SLVERR, 30'h0});
		wr(`BSC_OFF_STATUS, 32'h0000_0005, `BSC_RESP_SLVERR);
		rc("status", `BSC_OFF_STATUS, 32'h0000_0007, 32'h0000_0000);
		wr(`BSC_OFF_DUTY, 32'h0010_FF40, `BSC_RESP_OKAY);
		wr(`BSC_OFF_HAND, 32'h0004_FFFF, `BSC_RESP_OKAY);
		wr(`BSC_OFF_SENSE, 32'h0004_0180, `BSC_RESP_OKAY);
		rc("sense", `BSC_OFF_SENSE, 32'hFFFF_FFFF, 32'h0004_0180);
		// Single park, general cap then open-loop cap
		wr(`BSC_OFF_CTRL, 32'h0000_0001, `BSC_RESP_OKAY);
		count_hs(n1);
		repeat (144) @(posedge clock);
		count_hs(n2);
		check("ramp", 32'(n1 < n2), 32'h0000_0001);
		wait_hs(3'h4);
		check("park", 32'(gate), 32'h0000_0022);
		repeat (400) @(posedge clock);
		rc("open", `BSC_OFF_STATUS, 32'h0000_0077, 32'h0000_0005);
		rd_reg(`BSC_OFF_SPEED, s1, rr);
		n2 = 0;
		for (int k = 1; k < 200; k++) n2 |= int'(s1 == 32'(256 * k + 8 * k * k));
		check("speed", 32'(n2), 32'h0000_0001);
		count_hs(n1);
		wr(`BSC_OFF_CTRL, 32'h0000_0009, `BSC_RESP_OKAY);
		count_hs(n2);
		check("cap", 32'(n1 > 40 && n2 < 20), 32'h0000_0001);
		stop_run();
		// Double park, second pattern one step on
		wr(`BSC_OFF_CTRL, 32'h0000_0003, `BSC_RESP_OKAY);
		wait_hs(3'h1);
		check("park2", 32'(gate), 32'h0000_000A);
		repeat (900) @(posedge clock);
		rc("open2", `BSC_OFF_STATUS, 32'h0000_0077, 32'h0000_0015);
		stop_run();
		// Slow first cycle
		wr(`BSC_OFF_CTRL, 32'h0000_0007, `BSC_RESP_OKAY);
		rc("slow", `BSC_OFF_STATUS, 32'h0000_0007, 32'h0000_0004);
		repeat (300) @(posedge clock);
		rc("slow_open", `BSC_OFF_STATUS, 32'h0000_0007, 32'h0000_0005);
		stop_run();
		// Inductive sensing in both release modes
		for (int m = 0; m < 2; m++) begin
			seen_q.delete();
			last = '0;
			rec = 1'b1;
			wr(`BSC_OFF_CTRL, 32'h0000_0005 | (m << 4), `BSC_RESP_OKAY);
			repeat (1000) @(posedge clock);
			rec = 1'b0;
			for (int i = 0; i < 12; i++) begin
				ge = pats[i / 2];
				if (i % 2 == 1) ge = (m == 1) ? 6'h00 : (ge & 6'h07);
				check("sense", 32'(seen_q[i]), 32'(ge));
			end
			rc("best", `BSC_OFF_STATUS, 32'hFFE0_03F7, 32'h0000_0015);
			if (m == 0) stop_run();
		end
		// Handoff by threshold, then zero-cross stepping
		wr(`BSC_OFF_HAND, 32'h0004_0000, `BSC_RESP_OKAY);
		repeat (50) @(posedge clock);
		rc("closed", `BSC_OFF_STATUS, 32'h0000_0007, 32'h0000_0006);
		rd_reg(`BSC_OFF_STATUS, s1, rr);
		repeat (300) @(posedge clock);
		rc("hold", `BSC_OFF_STATUS, 32'h0000_0070, s1 & 32'h0000_0070);
		spin <= 1'b1;
		repeat (120) @(posedge clock);
		rd_reg(`BSC_OFF_STATUS, s2, rr);
		check("step", 32'(s2[6:4] != s1[6:4]), 32'h0000_0001);
		spin <= 1'b0;
		stop_run();
		// Automatic handoff ignores the high threshold
		wr(`BSC_OFF_HAND, 32'h0004_FFFF, `BSC_RESP_OKAY);
		wr(`BSC_OFF_CTRL, 32'h0000_0025, `BSC_RESP_OKAY);
		repeat (1000) @(posedge clock);
		rc("auto", `BSC_OFF_STATUS, 32'h0000_0007, 32'h0000_0006);
		give_verdict();
	end
endmodule : bsc_startup_commutation_bench
bind bsc_startup_commutation bsc_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clock, .rst, .ce,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phase_current,
	.bemf_zc, .duty_cmd, .gate);
